// [timer2_capture_reload.sv]
// Added by the designer: the plain strobed port.
`include "timer2_consts.svh"
module timer2_capture_reload
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Pins
  input  wire logic       count_input_pin,
  input  wire logic       trigger_pin,
  output logic            clock_out,
  // Serial port and interrupt
  input  wire logic       timer1_overflow,
  output logic            rx_baud_tick,
  output logic            tx_baud_tick,
  output logic            timer_irq
);
  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  assign rst_n = rst_sync_reg[1];

  // ==========================================================
  // Registers
  logic [7:0]  control_reg;
  logic [7:0]  mode_reg;
  logic        speed_reg;
  logic [15:0] count_reg;
  logic [15:0] cap_reg;
  logic        trig_d_reg;
  logic        cnt_d_reg;
  logic [3:0]  pre_reg;
  logic        clk_out_reg;
  logic [7:0]  rdata_reg;

  // ==========================================================
  // Address decode
  // Shared by the write strobes and the read selection
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] want);
    return a == want;
  endfunction

  wire wr_ctl  = wr && addr_hit(addr, `ADDR_TIMER_CONTROL);
  wire wr_mode = wr && addr_hit(addr, `ADDR_TIMER_MODE);
  wire wr_capl = wr && addr_hit(addr, `ADDR_CAP_LOW);
  wire wr_caph = wr && addr_hit(addr, `ADDR_CAP_HIGH);
  wire wr_cntl = wr && addr_hit(addr, `ADDR_COUNT_LOW);
  wire wr_cnth = wr && addr_hit(addr, `ADDR_COUNT_HIGH);
  wire wr_ck   = wr && addr_hit(addr, `ADDR_CLOCK_CONTROL);

  // ==========================================================
  // Control fields

  wire rclk   = control_reg[`BIT_RCLK];
  wire tclk   = control_reg[`BIT_TCLK];
  wire pin_en = control_reg[`BIT_PIN_EN];
  wire run    = control_reg[`BIT_RUN];
  wire ct_sel = control_reg[`BIT_CT_SEL];
  wire cp_rl  = control_reg[`BIT_CP_RL];
  wire down_count_enable   = mode_reg[`BIT_DOWN_COUNT_ENABLE];
  wire baud   = rclk | tclk;

  timer2_pkg::mode_t mode;
  assign mode = baud ? timer2_pkg::MODE_BAUD :
                (cp_rl ? timer2_pkg::MODE_CAPTURE : timer2_pkg::MODE_RELOAD);

  // ==========================================================
  // Tick generation
  wire [3:0] div      = baud ? `BAUD_DIV : (speed_reg ? `FAST_DIV : `SLOW_DIV);
  wire       pre_wrap = (pre_reg == div);
  wire       pin_fall = cnt_d_reg & ~count_input_pin;
  // Baud ignores select; counter mode follows pin edges
  wire tick = run && (baud ? pre_wrap : (ct_sel ? pin_fall : pre_wrap));
  wire trig_fall = trig_d_reg & ~trigger_pin;
  wire trig_evt  = pin_en && !baud && trig_fall;

  // ==========================================================
  // Counter
  wire count_down = down_count_enable && (mode == timer2_pkg::MODE_RELOAD) && !trigger_pin;
  wire up_ovf     = tick && !count_down && (count_reg == `MAX_WORD);
  wire down_hit   = tick && count_down && (count_reg == cap_reg);
  wire ovf        = up_ovf || down_hit;
  wire reload_evt = (mode != timer2_pkg::MODE_CAPTURE && up_ovf)
                    || (mode == timer2_pkg::MODE_RELOAD && trig_evt && !down_count_enable);
  wire capture_evt = (mode == timer2_pkg::MODE_CAPTURE) && trig_evt;
  wire cap_clear   = capture_evt && mode_reg[`BIT_CAP_CLR];

  logic [15:0] count_next;
  always_comb
  begin
    count_next = count_reg;
    if (cap_clear)
      count_next = `RESET_WORD;
    else if (reload_evt)
      count_next = cap_reg;
    else if (down_hit)
      count_next = `MAX_WORD;
    else if (tick)
      count_next = count_down ? count_reg - 16'h0001 : count_reg + 16'h0001;
    if (wr_cntl)
      count_next[7:0] = wdata;
    if (wr_cnth)
      count_next[15:8] = wdata;
  end

  logic [15:0] cap_next;
  always_comb
  begin
    cap_next = capture_evt ? count_reg : cap_reg;
    if (wr_capl)
      cap_next[7:0] = wdata;
    if (wr_caph)
      cap_next[15:8] = wdata;
  end

  // ==========================================================
  // Flags
  wire ovf_set = ovf && !baud;
  wire ext_hw  = trig_evt && (mode != timer2_pkg::MODE_RELOAD || !down_count_enable)
                 || (mode == timer2_pkg::MODE_RELOAD && down_count_enable && ovf);
  logic [7:0] control_next;
  always_comb
  begin
    control_next = wr_ctl ? wdata : control_reg;
    if (ovf_set)
      control_next[`BIT_OVF] = 1'b1;
    if (ext_hw)
      control_next[`BIT_EXT] = 1'b1;
  end
  // Only a 0 to 1 write of the flag asks for service
  wire ext_sw_set = wr_ctl && wdata[`BIT_EXT] && !control_reg[`BIT_EXT];
  wire irq_next   = ovf_set || ext_sw_set || (ext_hw && trig_evt);

  // ==========================================================
  // Control and mode registers
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      control_reg <= `RESET_BYTE;
      mode_reg    <= `RESET_BYTE;
      speed_reg   <= 1'b0;
    end
    else
    begin
      control_reg <= control_next;
      if (wr_mode)
        mode_reg <= wdata & `MODE_WRITE_MASK;
      if (wr_ck)
        speed_reg <= wdata[`BIT_SPEED];
    end

  // ==========================================================
  // Count and capture storage
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      count_reg <= `RESET_WORD;
      cap_reg   <= `RESET_WORD;
    end
    else
    begin
      count_reg <= count_next;
      cap_reg   <= cap_next;
    end

  // ==========================================================
  // Pin samples
  // Reset to the idle high level, so no false edge follows reset
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      trig_d_reg <= 1'b1;
      cnt_d_reg  <= 1'b1;
    end
    else
    begin
      trig_d_reg <= trigger_pin;
      cnt_d_reg  <= count_input_pin;
    end

  // ==========================================================
  // Prescaler
  // Held at zero while halted, so the first tick is a full period
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      pre_reg <= 4'h0;
    else
      pre_reg <= (pre_wrap || !run) ? 4'h0 : pre_reg + 4'h1;

  // ==========================================================
  // Clock out and interrupt request
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      clk_out_reg <= 1'b0;
      timer_irq   <= 1'b0;
    end
    else
    begin
      if (!mode_reg[`BIT_CLK_OE])
        clk_out_reg <= 1'b0;
      else if (up_ovf)
        clk_out_reg <= ~clk_out_reg;
      timer_irq <= irq_next;
    end

  // ==========================================================
  // Read path
  // Unmapped addresses read as zero
  wire [7:0] read_word =
    addr_hit(addr, `ADDR_TIMER_CONTROL) ? control_reg :
    addr_hit(addr, `ADDR_TIMER_MODE)    ? mode_reg :
    addr_hit(addr, `ADDR_CAP_LOW)       ? cap_reg[7:0] :
    addr_hit(addr, `ADDR_CAP_HIGH)      ? cap_reg[15:8] :
    addr_hit(addr, `ADDR_COUNT_LOW)     ? count_reg[7:0] :
    addr_hit(addr, `ADDR_COUNT_HIGH)    ? count_reg[15:8] :
    addr_hit(addr, `ADDR_CLOCK_CONTROL) ? {2'b00, speed_reg, 5'b00000} :
    `RESET_BYTE;

  // Holds the last read between strobes
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      rdata_reg <= `RESET_BYTE;
    else if (rd)
      rdata_reg <= read_word;

  assign rdata     = rdata_reg;
  assign clock_out = clk_out_reg;
  // Timer 1 path unless this timer selected
  assign rx_baud_tick = rclk ? up_ovf : timer1_overflow;
  assign tx_baud_tick = tclk ? up_ovf : timer1_overflow;

  // ==========================================================
  // Checks
  chk_ovf_baud_block: assert property (@(posedge mclk) disable iff (!rst_n)
    (baud && !wr_ctl) |=> !$rose(control_reg[`BIT_OVF]))
    else $error("overflow flag set in baud mode");
  chk_ovf_sets: assert property (@(posedge mclk) disable iff (!rst_n)
    ovf_set |=> control_reg[`BIT_OVF])
    else $error("overflow flag missed");
  chk_ovf_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (control_reg[`BIT_OVF] && !wr_ctl) |=> control_reg[`BIT_OVF])
    else $error("overflow flag cleared by hardware");
  chk_halt_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
    (!run && !wr_cntl && !wr_cnth && !trig_evt) |=> $stable(count_reg))
    else $error("count moved while halted");
  chk_capture_copy: assert property (@(posedge mclk) disable iff (!rst_n)
    (capture_evt && !wr_capl && !wr_caph) |=> cap_reg == $past(count_reg))
    else $error("capture value wrong");
  chk_reload_load: assert property (@(posedge mclk) disable iff (!rst_n)
    (reload_evt && !cap_clear && !wr_cntl && !wr_cnth) |=> count_reg == $past(cap_reg))
    else $error("reload value wrong");
  chk_cap_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (cap_clear && !wr_cntl && !wr_cnth) |=> count_reg == `RESET_WORD)
    else $error("counter not cleared after capture");
  chk_ext_edge: assert property (@(posedge mclk) disable iff (!rst_n)
    (trig_evt && !down_count_enable) |=> control_reg[`BIT_EXT] && timer_irq)
    else $error("external flag or request missed");
  chk_clk_out_off: assert property (@(posedge mclk) disable iff (!rst_n)
    !mode_reg[`BIT_CLK_OE] |=> !clock_out)
    else $error("clock out active while disabled");
  chk_rx_select: assert property (@(posedge mclk) disable iff (!rst_n)
    !rclk |-> rx_baud_tick == timer1_overflow)
    else $error("receive time base wrong");

  chk_irq_sw_set: assert property (@(posedge mclk) disable iff (!rst_n)
    ext_sw_set |=> timer_irq)
    else $error("software flag set gave no request");

  chk_tx_select: assert property (@(posedge mclk) disable iff (!rst_n)
    !tclk |-> tx_baud_tick == timer1_overflow)
    else $error("transmit time base wrong");

  chk_baud_forced: assert property (@(posedge mclk) disable iff (!rst_n)
    (rclk || tclk) |-> mode == timer2_pkg::MODE_BAUD)
    else $error("clock select did not force baud mode");

  chk_pin_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
    (!pin_en && !(mode == timer2_pkg::MODE_RELOAD && down_count_enable) && !wr_ctl && !control_reg[`BIT_EXT])
    |=> !control_reg[`BIT_EXT])
    else $error("trigger acted while disabled");

  chk_run_moves: assert property (@(posedge mclk) disable iff (!rst_n)
    (tick && !count_down && !reload_evt && !cap_clear && !wr_cntl && !wr_cnth)
    |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("count did not advance");

  chk_pin_count: assert property (@(posedge mclk) disable iff (!rst_n)
    (run && ct_sel && !baud && !pin_fall) |-> !tick)
    else $error("counter mode ticked without pin edge");

  chk_baud_rate: assert property (@(posedge mclk) disable iff (!rst_n)
    (baud && tick) |=> !tick)
    else $error("baud tick faster than two clocks");

  chk_baud_reload: assert property (@(posedge mclk) disable iff (!rst_n)
    (baud && up_ovf && !wr_cntl && !wr_cnth) |=> count_reg == $past(cap_reg))
    else $error("baud overflow did not reload");

  chk_trig_reload: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == timer2_pkg::MODE_RELOAD && !down_count_enable && trig_evt && !wr_cntl && !wr_cnth)
    |=> count_reg == $past(cap_reg))
    else $error("trigger edge did not reload");

  chk_down_step: assert property (@(posedge mclk) disable iff (!rst_n)
    (tick && count_down && !down_hit && !wr_cntl && !wr_cnth)
    |=> count_reg == $past(count_reg) - 16'h0001)
    else $error("down count step wrong");

  chk_up_when_high: assert property (@(posedge mclk) disable iff (!rst_n)
    (down_count_enable && trigger_pin) |-> !count_down)
    else $error("counted down with trigger high");

  // ==========================================================
  // Scenario covers
  cov_overflow: cover property (@(posedge mclk) disable iff (!rst_n) up_ovf && !baud);
  cov_clk_out:  cover property (@(posedge mclk) disable iff (!rst_n) $rose(clock_out));
  cov_capture:  cover property (@(posedge mclk) disable iff (!rst_n) capture_evt);
  cov_baud:     cover property (@(posedge mclk) disable iff (!rst_n) baud && up_ovf);
  cov_down_hit: cover property (@(posedge mclk) disable iff (!rst_n) down_hit);
endmodule // timer2_capture_reload

// [timer2_capture_reload_bench.sv]
module timer2_capture_reload_bench;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
  // ====================
  // Harness
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_q = 1'b0;
  logic [7:0]  rdata, v;
  logic        count_input_pin, trigger_pin, clock_out, timer1_overflow;
  logic        rx_baud_tick, tx_baud_tick, timer_irq;
  logic [8:0]  note;
  logic [8:0]  notes[$];
  logic [15:0] seed = 16'hCFE0;
  logic [7:0]  idle_map[8] = '{8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'h8E, 8'h50};
  int          errors = 0;
  int          n_tests = 0;
  int          irqs = 0;
  int          rxs = 0;
  int          txs = 0;
  timer2_capture_reload u_timer2_capture_reload
  (
    .mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .count_input_pin(count_input_pin), .trigger_pin(trigger_pin), .clock_out(clock_out),
    .timer1_overflow(timer1_overflow), .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick),
    .timer_irq(timer_irq)
  );
  timer2_far_side u_far
  (
    .mclk(mclk), .count_input_pin(count_input_pin), .trigger_pin(trigger_pin),
    .timer1_overflow(timer1_overflow)
  );
  always #25 mclk = ~mclk;
  // Read data stand one clock after the strobe, so the note is taken then
  always @(posedge mclk)
  begin
    if (rd_q)
    begin
      note = notes.pop_front();
      if (note[8])
        `CHK("rdata", note[7:0], rdata)
    end
    rd_q <= rd;
    irqs += (timer_irq === 1'b1);
    rxs += (rx_baud_tick === 1'b1);
    txs += (tx_baud_tick === 1'b1);
  end
  // ====================
  // Bus tasks
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // A note with its top bit clear is a raw read, left in v for the caller
  task automatic rd_reg(input logic [7:0] a, input logic c, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    notes.push_back({c, e});
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // ====================
  // Sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (idle_map[i])
      rd_reg(idle_map[i], 1'b1, 8'h00);
    wr_reg(8'hC9, 8'hFF);
    rd_reg(8'hC9, 1'b1, 8'h0B);
    wr_reg(8'h50, 8'hFF);
    rd_reg(8'h50, 1'b1, 8'h00);
    repeat (4)
    begin
      seed = lfsr(seed);
      wr_reg(8'hCB, seed[15:8]);
      rd_reg(8'hCB, 1'b1, seed[15:8]);
    end
    wr_reg(8'hC9, 8'h00);
    wr_reg(8'hC8, 8'h40);
    rd_reg(8'hC8, 1'b1, 8'h40);
    wr_reg(8'hC8, 8'h80);
    rd_reg(8'hC8, 1'b1, 8'h80);
    `CHK("irq", 1, irqs);
    wr_reg(8'hCD, 8'h00);
    wr_reg(8'hC8, 8'h06);
    repeat (5)
    begin
      u_far.drive(1'b0, 1'b1);
      u_far.drive(1'b1, 1'b1);
    end
    wr_reg(8'hC8, 8'h02);
    rd_reg(8'hCC, 1'b1, 8'h05);
    u_far.drive(1'b0, 1'b1);
    u_far.drive(1'b1, 1'b1);
    rd_reg(8'hCC, 1'b1, 8'h05);
    // Fast ticks keep the overflow waits short
    wr_reg(8'hC9, 8'h02);
    wr_reg(8'h8E, 8'h20);
    wr_reg(8'hCA, 8'h34);
    wr_reg(8'hCB, 8'h12);
    wr_reg(8'hCC, 8'hFE);
    wr_reg(8'hCD, 8'hFF);
    wr_reg(8'hC8, 8'h04);
    repeat (20) @(posedge mclk);
    rd_reg(8'hC8, 1'b1, 8'h84);
    `CHK("clock out", 1'b1, clock_out);
    wr_reg(8'hC8, 8'h00);
    rd_reg(8'hCD, 1'b1, 8'h12);
    wr_reg(8'hCA, 8'h00);
    wr_reg(8'hCB, 8'h00);
    irqs = 0;
    wr_reg(8'hC8, 8'h05);
    u_far.drive(1'b1, 1'b0);
    u_far.drive(1'b1, 1'b1);
    rd_reg(8'hC8, 1'b1, 8'h05);
    wr_reg(8'hC8, 8'h0D);
    u_far.drive(1'b1, 1'b0);
    u_far.drive(1'b1, 1'b1);
    rd_reg(8'hC8, 1'b1, 8'h4D);
    rd_reg(8'hCA, 1'b0, 8'h00);
    `CHK("capture", 1'b1, v != 8'h00);
    `CHK("irq", 1, irqs);
    // Control cleared first, so pin enable is low and no capture lands on the down-count setup
    wr_reg(8'hC8, 8'h00);
    wr_reg(8'hC9, 8'h01);
    wr_reg(8'hCA, 8'h03);
    wr_reg(8'hCB, 8'h00);
    wr_reg(8'hCC, 8'h06);
    wr_reg(8'hCD, 8'h00);
    u_far.drive(1'b1, 1'b0);
    wr_reg(8'hC8, 8'h04);
    repeat (20) @(posedge mclk);
    rd_reg(8'hC8, 1'b0, 8'h00);
    `CHK("down hit", 1'b1, v[7]);
    wr_reg(8'hC8, 8'h00);
    rd_reg(8'hCD, 1'b1, 8'hFF);
    u_far.drive(1'b1, 1'b1);
    wr_reg(8'hC9, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      wr_reg(8'hC8, 8'h00);
      wr_reg(8'hCA, 8'hF0);
      wr_reg(8'hCB, 8'hFF);
      wr_reg(8'hCC, 8'hF0);
      wr_reg(8'hCD, 8'hFF);
      wr_reg(8'hC8, i ? 8'h15 : 8'h25);
      // Off the edge, so the tally process never races the clear or the look
      #1;
      rxs = 0;
      txs = 0;
      repeat (336) @(posedge mclk);
      #1;
      `CHK("rx ticks", i ? 42 : 10, rxs);
      `CHK("tx ticks", i ? 10 : 42, txs);
      rd_reg(8'hC8, 1'b1, i ? 8'h15 : 8'h25);
    end
    report_and_stop();
  end
endmodule // timer2_capture_reload_bench

// [timer2_consts.svh]
`ifndef TIMER2_CONSTS_SVH
`define TIMER2_CONSTS_SVH
// Operation
// - Overflow flag sets on 16-bit rollover, or down-count reaching capture value.
// - Overflow flag sets only when both clock selects are zero.
// - Only software clears overflow flag; software may also set or clear it.
// - External flag sets on trigger falling edge or overflow per mode bits.
// - Software set or trigger edge of external flag requests timer interrupt.
// - Receive clock select picks timer 1 or this timer for serial receive.
// - Transmit clock select picks timer 1 or this timer for serial transmit.
// - Either clock select bit forces baud-rate generator mode.
// - Pin enable low ignores trigger; high, outside baud mode, edge captures/reloads.
// - Run control low halts and preserves count; high lets counting proceed. An enabled trigger edge still reloads or clears the count while halted.
// - Select low counts internal ticks at chosen speed; high counts pin edges.
// - Baud mode advances once every two clocks regardless of select.
// - Clock select set ignores capture select and reloads on every overflow.
// - Capture select low reloads on overflow and on enabled trigger edge.
// - Capture select high with pin enable copies count on trigger edge.
// - Capture auto-clear resets counter after a capture.
// - Clock-out enable switches the clock-out function on or off.
// - Down-count enable with trigger level sets direction in auto-reload.
`define ADDR_TIMER_CONTROL   8'hC8
`define ADDR_TIMER_MODE      8'hC9
`define ADDR_CAP_LOW         8'hCA
`define ADDR_CAP_HIGH        8'hCB
`define ADDR_COUNT_LOW       8'hCC
`define ADDR_COUNT_HIGH      8'hCD
`define ADDR_CLOCK_CONTROL   8'h8E
`define BIT_OVF              7
`define BIT_EXT              6
`define BIT_RCLK             5
`define BIT_TCLK             4
`define BIT_PIN_EN           3
`define BIT_RUN              2
`define BIT_CT_SEL           1
`define BIT_CP_RL            0
`define BIT_CAP_CLR          3
`define BIT_CLK_OE           1
`define BIT_DOWN_COUNT_ENABLE             0
`define BIT_SPEED            5
`define RESET_BYTE           8'h00
`define RESET_WORD           16'h0000
`define MAX_WORD             16'hFFFF
`define MODE_WRITE_MASK      8'h0B
`define SLOW_DIV             4'hB
`define FAST_DIV             4'h3
`define BAUD_DIV             4'h1
`endif

// [timer2_far_side.sv]
module timer2_far_side
(
  // Clock
  input  wire logic mclk,
  // Pins toward the timer
  output logic      count_input_pin,
  output logic      trigger_pin,
  output logic      timer1_overflow
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // Pins and timer 1 stand-in
  logic [2:0] div_reg = 3'h0;
  initial
  begin
    count_input_pin = 1'b1;
    trigger_pin = 1'b1;
    timer1_overflow = 1'b0;
  end
  // Free running, like the real timer 1: one pulse in eight clocks
  always @(posedge mclk)
  begin
    div_reg <= div_reg + 3'h1;
    timer1_overflow <= (div_reg == 3'h7);
  end
  // Levels held four clocks, since the pins are sampled, not edge-clocked
  task automatic drive(input logic cnt, input logic trg);
    @(posedge mclk);
    count_input_pin <= cnt;
    trigger_pin <= trg;
    repeat (3) @(posedge mclk);
  endtask
endmodule // timer2_far_side

// [timer2_pkg.sv]
package timer2_pkg;
  typedef enum logic [1:0] {MODE_CAPTURE, MODE_RELOAD, MODE_BAUD} mode_t;
endpackage
